// File: src/apco_pkg.sv
// Constants, state codes and state layouts for the axis pulse command output.
// Assumes one 20 MHz system clock and a synchronous active-low reset.
package apco_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int AXES = 4;
  localparam int DIST_W = 28;
  localparam int VEL_W = 25;
  localparam int TMR_W = 8;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  // Least pulse width and least sign setup/hold, rounded up to cycles
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TMR_W-1:0] PULSE_LAST = TMR_W'(PULSE_CYC - 1);
  localparam logic [TMR_W-1:0] SETTLE_LAST = TMR_W'(SETTLE_CYC - 1);

  // ==========================================================================
  // Encodings
  localparam logic FMT_STEP_SIGN = 1'b0;
  localparam logic FMT_TWO_PULSE = 1'b1;
  localparam logic SIGN_PLUS = 1'b0;
  localparam logic SIGN_MINUS = 1'b1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARM = 5'h02,
    ST_SETTLE = 5'h04,
    ST_RUN = 5'h08,
    ST_HOLD = 5'h10
  } apco_state_e;

  // ==========================================================================
  // State layouts
  typedef struct packed {
    apco_state_e state;
    logic [DIST_W-1:0] remain;
    logic [VEL_W-1:0] vel;
    logic minus;
    logic two_pulse;
    logic active_low;
    logic [TMR_W-1:0] timer;
    logic pulse_on;
    logic out_pin;
    logic dir_pin;
    logic done;
  } apco_axis_s;

  typedef struct packed {
    apco_axis_s [AXES-1:0] axis;
    logic [1:0] begin_sync;
    logic [1:0] halt_sync;
    logic begin_drive;
    logic halt_drive;
  } apco_top_s;

  typedef struct packed {
    logic [VEL_W:0] acc;
    logic tick;
  } apco_rate_s;

  localparam apco_axis_s AXIS_RST = '{state: ST_IDLE, default: '0};
  localparam apco_rate_s RATE_RST = '{default: '0};

endpackage : apco_pkg

// File: src/apco_rate_if.sv
// Rate request and tick between the axis sequencer and its rate generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface apco_rate_if;
  logic run;
  logic [apco_pkg::VEL_W-1:0] velocity;
  logic tick;
  modport src (output run, output velocity, input tick);
  modport gen (input run, input velocity, output tick);
endinterface : apco_rate_if

// File: src/apco_rate_gen.sv
// Fractional rate generator: one tick per 1/velocity seconds on average.
// Assumes velocity below the clock rate; held at zero while not running.
`timescale 1ns/1ps
module apco_rate_gen (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Rate request
  apco_rate_if.gen rate
);

  localparam logic [apco_pkg::VEL_W:0] HZ = (apco_pkg::VEL_W+1)'(apco_pkg::CLK_HZ);

  apco_pkg::apco_rate_s q;
  apco_pkg::apco_rate_s next_q;
  logic [apco_pkg::VEL_W:0] sum;

  // ==========================================================================
  // Accumulate pulses per second, wrap at the clock rate
  always_comb begin
    next_q = q;
    sum = q.acc + {1'b0, rate.velocity};
    next_q.tick = 1'b0;
    if (!rate.run) begin
      next_q.acc = '0;
    end else if (sum >= HZ) begin
      // Remainder kept, so long-run rate is exact
      next_q.acc = sum - HZ;
      next_q.tick = 1'b1;
    end else begin
      next_q.acc = sum;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      q <= apco_pkg::RATE_RST;
    end else begin
      q <= next_q;
    end
  end

  assign rate.tick = q.tick;

endmodule : apco_rate_gen

// File: src/apco_pulse_top.sv
// Four-axis pulse command output with shared begin and halt lines.
// Assumes command and configuration inputs come from logic on i_clk_sys;
// the shared lines are open-drain, active low, with an external pull-up.
// Config and commands are plain ports; software reaches no register here.
`timescale 1ns/1ps
module apco_pulse_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Per-axis configuration
  input wire logic [apco_pkg::AXES-1:0] i_two_pulse_format,
  input wire logic [apco_pkg::AXES-1:0] i_pulse_active_low,
  input wire logic [apco_pkg::AXES-1:0] i_halt_follow,
  // Per-axis move command
  input wire logic [apco_pkg::AXES-1:0] i_cmd_valid,
  input wire logic [apco_pkg::AXES-1:0][apco_pkg::DIST_W-1:0] i_cmd_dist,
  input wire logic [apco_pkg::AXES-1:0][apco_pkg::VEL_W-1:0] i_cmd_vel,
  input wire logic [apco_pkg::AXES-1:0] i_cmd_minus,
  input wire logic [apco_pkg::AXES-1:0] i_cmd_wait_begin,
  output logic [apco_pkg::AXES-1:0] o_cmd_ready,
  output logic [apco_pkg::AXES-1:0] o_busy,
  output logic [apco_pkg::AXES-1:0] o_done,
  // Software requests to pull the shared lines
  input wire logic [apco_pkg::AXES-1:0] i_drive_begin,
  input wire logic [apco_pkg::AXES-1:0] i_drive_halt,
  // Motor driver pins: command pulse or plus_pulse_pin, sign or minus_pulse_pin
  output logic [apco_pkg::AXES-1:0] o_pulse_pin,
  output logic [apco_pkg::AXES-1:0] o_sign_pin,
  // Shared sync_begin_line, open drain
  input wire logic i_sync_begin_line,
  output logic o_sync_begin_line,
  output logic o_sync_begin_line_oe_n,
  // Shared sync_halt_line, open drain
  input wire logic i_sync_halt_line,
  output logic o_sync_halt_line,
  output logic o_sync_halt_line_oe_n
);

  apco_pkg::apco_top_s q;
  apco_pkg::apco_top_s next_q;
  logic begin_active;
  logic halt_active;
  logic begin_req;
  logic halt_req;
  logic [apco_pkg::AXES-1:0] halt_hit;
  logic [apco_pkg::AXES-1:0] rate_run;
  logic [apco_pkg::AXES-1:0] rate_tick;

  // ==========================================================================
  // Rate generators, one per axis
  for (genvar g = 0; g < apco_pkg::AXES; g++) begin : g_axis
    apco_rate_if rif ();
    assign rif.run = rate_run[g];
    assign rif.velocity = q.axis[g].vel;
    assign rate_tick[g] = rif.tick;
    assign rate_run[g] = (q.axis[g].state == apco_pkg::ST_RUN) && (q.axis[g].remain != '0);
    apco_rate_gen u_rate (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .rate(rif.gen)
    );
  end

  // ==========================================================================
  // Shared line sensing
  // One wired node per line; own pull seen at once, others after sync
  // A released own pull stays seen two more cycles through the sync stages
  assign begin_active = !q.begin_sync[1] || q.begin_drive;
  assign halt_active = !q.halt_sync[1] || q.halt_drive;

  // ==========================================================================
  // Software pulls: any axis may pull either shared line
  assign begin_req = |i_drive_begin;
  assign halt_req = |i_drive_halt;

  // ==========================================================================
  // Halt as seen by each axis that follows it
  for (genvar g = 0; g < apco_pkg::AXES; g++) begin : g_halt
    assign halt_hit[g] = halt_active && i_halt_follow[g];
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    apco_pkg::apco_axis_s ax;
    logic act;
    ax = apco_pkg::AXIS_RST;
    act = 1'b0;
    next_q = q;
    // Pins sensed through two flops; first stage feeds only the second
    next_q.begin_sync = {q.begin_sync[0], i_sync_begin_line};
    next_q.halt_sync = {q.halt_sync[0], i_sync_halt_line};
    next_q.begin_drive = begin_req;
    next_q.halt_drive = halt_req;
    for (int a = 0; a < apco_pkg::AXES; a++) begin
      ax = q.axis[a];
      ax.done = 1'b0;
      unique case (q.axis[a].state)
        apco_pkg::ST_IDLE: begin
          // Idle pins follow live configuration
          ax.two_pulse = i_two_pulse_format[a];
          ax.active_low = i_pulse_active_low[a];
          ax.pulse_on = 1'b0;
          if (i_cmd_valid[a]) begin
            ax.remain = i_cmd_dist[a];
            ax.vel = i_cmd_vel[a];
            ax.minus = i_cmd_minus[a] ? apco_pkg::SIGN_MINUS : apco_pkg::SIGN_PLUS;
            ax.timer = apco_pkg::SETTLE_LAST;
            // Zero-length move answers done without going busy
            if (i_cmd_dist[a] == '0) begin
              ax.done = 1'b1;
            end else if (i_cmd_wait_begin[a]) begin
              ax.state = apco_pkg::ST_ARM;
            end else begin
              ax.state = apco_pkg::ST_SETTLE;
            end
          end
        end
        apco_pkg::ST_ARM: begin
          // Halt beats begin when both arrive together
          if (halt_hit[a]) begin
            ax.state = apco_pkg::ST_IDLE;
            ax.done = 1'b1;
          end else if (begin_active) begin
            // All armed axes leave on the same edge
            ax.state = apco_pkg::ST_SETTLE;
          end
        end
        apco_pkg::ST_SETTLE: begin
          // A halt here empties the move; sign still gets its hold time
          if (halt_hit[a]) begin
            ax.remain = '0;
          end
          // Sign already at its new level; wait setup before first pulse
          if (q.axis[a].timer == '0) begin
            ax.state = apco_pkg::ST_RUN;
          end else begin
            ax.timer = q.axis[a].timer - 1'b1;
          end
        end
        apco_pkg::ST_RUN: begin
          if (halt_hit[a]) begin
            // Pulse in flight still completes at full width
            ax.remain = '0;
          end
          if (q.axis[a].pulse_on) begin
            if (q.axis[a].timer == '0) begin
              ax.pulse_on = 1'b0;
            end else begin
              ax.timer = q.axis[a].timer - 1'b1;
            end
          end else if (ax.remain == '0) begin
            ax.state = apco_pkg::ST_HOLD;
            ax.timer = apco_pkg::SETTLE_LAST;
          end else if (rate_tick[a]) begin
            // Ticks during a pulse are lost: rate capped by pulse width
            ax.pulse_on = 1'b1;
            ax.timer = apco_pkg::PULSE_LAST;
            ax.remain = q.axis[a].remain - 1'b1;
          end
        end
        apco_pkg::ST_HOLD: begin
          // Sign held after last pulse ends
          if (q.axis[a].timer == '0) begin
            ax.state = apco_pkg::ST_IDLE;
            ax.done = 1'b1;
          end else begin
            ax.timer = q.axis[a].timer - 1'b1;
          end
        end
        default: begin
          ax = apco_pkg::AXIS_RST;
        end
      endcase
      // Pin mapping from the next pulse state, so pins come from flops
      // Polarity never touches the sign level in step form
      act = ax.pulse_on;
      if (ax.two_pulse == apco_pkg::FMT_TWO_PULSE) begin
        ax.out_pin = (act && !ax.minus) ^ ax.active_low;
        ax.dir_pin = (act && ax.minus) ^ ax.active_low;
      end else begin
        ax.out_pin = act ^ ax.active_low;
        ax.dir_pin = ax.minus;
      end
      next_q.axis[a] = ax;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      for (int a = 0; a < apco_pkg::AXES; a++) begin
        q.axis[a] <= apco_pkg::AXIS_RST;
      end
      // Sync stages start at the idle high level: no false pull after reset
      q.begin_sync <= 2'h3;
      q.halt_sync <= 2'h3;
      q.begin_drive <= 1'b0;
      q.halt_drive <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs
  for (genvar g = 0; g < apco_pkg::AXES; g++) begin : g_out
    assign o_pulse_pin[g] = q.axis[g].out_pin;
    assign o_sign_pin[g] = q.axis[g].dir_pin;
    assign o_done[g] = q.axis[g].done;
    // Ready decoded from the state flop, so it may be combinational
    assign o_cmd_ready[g] = (q.axis[g].state == apco_pkg::ST_IDLE);
    assign o_busy[g] = (q.axis[g].state != apco_pkg::ST_IDLE);
  end

  // ==========================================================================
  // Shared line drivers
  // Open drain: only ever pull low, so cascaded boards can share the node
  assign o_sync_begin_line = 1'b0;
  assign o_sync_begin_line_oe_n = !q.begin_drive;
  assign o_sync_halt_line = 1'b0;
  assign o_sync_halt_line_oe_n = !q.halt_drive;

endmodule : apco_pulse_top

// File: dv/apco_pulse_top_assertions.sv
// Concurrent checks on axis 0 and the shared lines of the pulse command top.
// Assumes the bench holds format and polarity steady while an axis is busy.
`timescale 1ns/1ps
module apco_pulse_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Watched inputs
  input wire logic [3:0] i_two_pulse_format,
  input wire logic [3:0] i_pulse_active_low,
  input wire logic [3:0] i_cmd_valid,
  input wire logic [3:0][27:0] i_cmd_dist,
  input wire logic [3:0] i_drive_begin,
  input wire logic [3:0] i_drive_halt,
  // Watched outputs
  input wire logic [3:0] o_cmd_ready,
  input wire logic [3:0] o_busy,
  input wire logic [3:0] o_done,
  input wire logic [3:0] o_pulse_pin,
  input wire logic [3:0] o_sign_pin,
  input wire logic o_sync_begin_line,
  input wire logic o_sync_begin_line_oe_n,
  input wire logic o_sync_halt_line,
  input wire logic o_sync_halt_line_oe_n
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  logic act0;
  assign act0 = o_pulse_pin[0] ^ i_pulse_active_low[0];
  // ==========================================================================
  // Command and pins
  a_take_busy: assert property (i_cmd_valid[0] && o_cmd_ready[0] && i_cmd_dist[0] != 28'h0
    |=> o_busy[0] && !o_done[0]) else $error("busy missing after take");
  a_zero_done: assert property (i_cmd_valid[0] && o_cmd_ready[0] && i_cmd_dist[0] == 28'h0
    |=> o_done[0] && o_cmd_ready[0]) else $error("zero move not done at once");
  a_pulse_width: assert property (o_busy[0] && $rose(act0) |-> ##19 act0 ##1 !act0)
    else $error("pulse width wrong");
  a_sign_setup: assert property (o_busy[0] && !i_two_pulse_format[0] && $rose(act0)
    |-> $past(o_sign_pin[0], 10) == o_sign_pin[0]) else $error("sign not settled");
  a_sign_steady: assert property (o_busy[0] && $past(o_busy[0]) && !i_two_pulse_format[0]
    |-> $stable(o_sign_pin[0])) else $error("sign moved in a move");
  a_other_idle: assert property (o_busy[0] && i_two_pulse_format[0] && act0
    |-> o_sign_pin[0] == i_pulse_active_low[0]) else $error("both pins active");
  // ==========================================================================
  // Shared lines
  a_begin_drive: assert property (1'b1 |=> o_sync_begin_line_oe_n == !$past(|i_drive_begin))
    else $error("begin drive wrong");
  a_halt_drive: assert property (1'b1 |=> o_sync_halt_line_oe_n == !$past(|i_drive_halt))
    else $error("halt drive wrong");
  a_open_drain: assert property (!o_sync_begin_line && !o_sync_halt_line)
    else $error("shared line driven high");
endmodule : apco_pulse_checker

bind apco_pulse_top apco_pulse_checker u_apco_pulse_checker (.*);

// File: dv/apco_drive_model.sv
// Motor driver model: counts plus and minus steps per axis.
// Assumes it sees the same format and polarity as the design.
`timescale 1ns/1ps
module apco_drive_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Pins and their meaning
  input wire logic [3:0] i_pulse_pin,
  input wire logic [3:0] i_sign_pin,
  input wire logic [3:0] i_two_pulse,
  input wire logic [3:0] i_active_low,
  // Step counts
  output logic [3:0][15:0] o_plus_count,
  output logic [3:0][15:0] o_minus_count
);
  logic [3:0] last_p;
  logic [3:0] last_s;
  always_ff @(posedge i_clk_sys) begin
    last_p <= i_pulse_pin ^ i_active_low;
    last_s <= i_sign_pin ^ i_active_low;
    for (int a = 0; a < 4; a++) begin
      if (!i_nrst) begin
        o_plus_count[a] <= 16'h0;
        o_minus_count[a] <= 16'h0;
      end else if ((i_pulse_pin[a] ^ i_active_low[a]) && !last_p[a]) begin
        if (i_two_pulse[a] || i_sign_pin[a] == apco_pkg::SIGN_PLUS) begin
          o_plus_count[a] <= o_plus_count[a] + 16'h1;
        end else begin
          o_minus_count[a] <= o_minus_count[a] + 16'h1;
        end
      end else if (i_two_pulse[a] && (i_sign_pin[a] ^ i_active_low[a]) && !last_s[a]) begin
        o_minus_count[a] <= o_minus_count[a] + 16'h1;
      end
    end
  end
endmodule : apco_drive_model

// File: dv/axis_pulse_command_output_tb.sv
// Self-checking bench for the pulse command top and a driver model.
// Assumes a 20 MHz clock; the shared lines have their pull-up modelled here.
`timescale 1ns/1ps
module axis_pulse_command_output_tb;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_two_pulse_format = 4'h0, i_pulse_active_low = 4'h0, i_halt_follow = 4'h0;
  logic [3:0] i_cmd_valid = 4'h0, i_cmd_minus = 4'h0, i_cmd_wait_begin = 4'h0;
  logic [3:0] i_drive_begin = 4'h0, i_drive_halt = 4'h0, o_cmd_ready, o_busy, o_done, o_pulse_pin, o_sign_pin;
  logic [3:0][27:0] i_cmd_dist = '0;
  logic [3:0][24:0] i_cmd_vel = '0;
  logic ext_begin_n = 1'b1, o_sync_begin_line, o_sync_begin_line_oe_n, o_sync_halt_line, o_sync_halt_line_oe_n;
  wire i_sync_begin_line = (o_sync_begin_line_oe_n ? 1'b1 : o_sync_begin_line) & ext_begin_n;
  wire i_sync_halt_line = o_sync_halt_line_oe_n ? 1'b1 : o_sync_halt_line;
  logic [3:0][15:0] pc, mc;
  int fail_count = 0;
  int comparisons = 0;
  always #25 i_clk_sys = ~i_clk_sys;
  apco_pulse_top uut (.*);
  apco_drive_model u_drv (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_pulse_pin(o_pulse_pin),
    .i_sign_pin(o_sign_pin), .i_two_pulse(i_two_pulse_format), .i_active_low(i_pulse_active_low),
    .o_plus_count(pc), .o_minus_count(mc));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic cfg(input int a, input logic f, input logic p, input logic h);
    @(posedge i_clk_sys);
    i_two_pulse_format[a] <= f;
    i_pulse_active_low[a] <= p;
    i_halt_follow[a] <= h;
    repeat (3) @(posedge i_clk_sys);
  endtask : cfg
  task automatic move(input int a, input logic [27:0] d, input logic [24:0] v, input logic m, input logic w);
    @(posedge i_clk_sys);
    i_cmd_dist[a] <= d;
    i_cmd_vel[a] <= v;
    i_cmd_minus[a] <= m;
    i_cmd_wait_begin[a] <= w;
    i_cmd_valid[a] <= 1'b1;
    @(posedge i_clk_sys);
    i_cmd_valid[a] <= 1'b0;
  endtask : move
  task automatic wait_done(input int a, input int lim, output int n);
    // Done stands one cycle: look in the cycle right after the take too
    n = 1;
    #1;
    while (o_done[a] !== 1'b1 && n < lim) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (o_done[a] !== 1'b1) begin
      check("done within limit", 32'h1, {31'h0, o_done[a]});
      print_verdict();
    end
  endtask : wait_done
  // ==========================================================================
  // Scenarios
  task automatic sc_format(input logic f, input logic m, input logic p);
    int n;
    logic [15:0] p0;
    logic [15:0] m0;
    cfg(0, f, p, 1'b0);
    p0 = pc[0];
    m0 = mc[0];
    move(0, 28'h3, 25'h61A80, m, 1'b0);
    wait_done(0, 400, n);
    check("plus count", m ? 0 : 3, pc[0] - p0);
    check("minus count", m ? 3 : 0, mc[0] - m0);
    check("idle pulse level", p, o_pulse_pin[0]);
  endtask : sc_format
  task automatic sc_rate();
    int n;
    move(1, 28'h4, 25'h30D40, 1'b0, 1'b0);
    wait_done(1, 600, n);
    check("move span in range", 1, n >= 400 && n <= 470);
  endtask : sc_rate
  task automatic sc_zero();
    int n;
    logic [15:0] p0;
    p0 = pc[0];
    move(0, 28'h0, 25'h61A80, 1'b0, 1'b0);
    wait_done(0, 3, n);
    check("zero move latency", 1, n);
    check("zero move pulses", 0, pc[0] - p0);
    check("ready after zero move", 32'h1, {31'h0, o_cmd_ready[0]});
  endtask : sc_zero
  task automatic sc_begin();
    int n;
    logic [15:0] p3;
    p3 = pc[3];
    for (int a = 1; a < 4; a++) begin
      move(a, 28'h2, 25'h61A80, 1'b0, 1'b1);
    end
    repeat (30) @(posedge i_clk_sys);
    check("armed busy", 4'hE, o_busy);
    check("armed pulses", 0, pc[3] - p3);
    i_drive_begin[0] <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    check("begin line level", 0, i_sync_begin_line);
    @(posedge i_clk_sys);
    i_drive_begin[0] <= 1'b0;
    wait_done(3, 300, n);
    check("joint finish", 4'hE, o_done);
    check("joint pulses", 2, pc[3] - p3);
  endtask : sc_begin
  task automatic sc_ext();
    int n;
    logic [15:0] p2;
    p2 = pc[2];
    move(2, 28'h1, 25'h61A80, 1'b0, 1'b1);
    repeat (5) @(posedge i_clk_sys);
    ext_begin_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    ext_begin_n <= 1'b1;
    wait_done(2, 200, n);
    check("outside start pulses", 1, pc[2] - p2);
  endtask : sc_ext
  task automatic sc_halt();
    int n;
    logic [15:0] m3;
    cfg(3, 1'b0, 1'b0, 1'b1);
    m3 = mc[3];
    move(3, 28'h3E8, 25'h61A80, 1'b1, 1'b0);
    repeat (200) @(posedge i_clk_sys);
    move(3, 28'h5, 25'h61A80, 1'b0, 1'b0);
    i_drive_halt[0] <= 1'b1;
    wait_done(3, 60, n);
    check("halt line level", 32'h0, {31'h0, i_sync_halt_line});
    @(posedge i_clk_sys);
    i_drive_halt[0] <= 1'b0;
    check("halted early", 1, (mc[3] - m3) < 16'h3E8 && mc[3] != m3);
    repeat (3) @(posedge i_clk_sys);
    check("refused command", 0, o_busy[3]);
  endtask : sc_halt
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sc_format(i[2], i[1], i[0]);
    end
    sc_rate();
    sc_zero();
    sc_begin();
    sc_ext();
    sc_halt();
    print_verdict();
  end
endmodule : axis_pulse_command_output_tb
